// File: core/cdio_lines.sv
// four digital i/o lines with filters, drive select and soft outputs
// Behaviour
// RQ1: selector picks one of four lines
// RQ2: per-line direction, input or output
// RQ3: enable bit switches 3.3V rail onto pin
// RQ4: rail offered only on some lines
// RQ5: per-line inversion of logic sense
// RQ6: read selected line present level
// RQ7: packed level word, coherent snapshot
// RQ8: two filters, kind selector per line
// RQ9: width per line and filter kind
// RQ10: drive source used only in output
// RQ11: read-only circuit type, writes ignored
// RQ12: selector picks one soft output bit
// RQ13: write/read selected soft output bit
// RQ14: packed soft output word
// RQ15: deglitch accepts level after full width
// RQ16: debounce passes first edge, then locks
// RQ17: deglitch feeds debounce
// RQ18: two-flop sync, width rounded up
// RQ19: reset: inputs, no inversion, outputs low
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "cdio_defines.svh"

module cdio_lines (
	input  wire logic        sys_clk_i,    // 125 MHz clock
	input  wire logic        sys_rst_i,    // sync reset, high
	input  wire logic        clk_en_i,     // freezes state when low
	input  wire logic [5:0]  reg_addr_i,   // byte address
	input  wire logic [31:0] reg_wdata_i,  // write data
	input  wire logic        reg_wr_i,     // write strobe
	input  wire logic        reg_rd_i,     // read strobe
	output logic      [31:0] reg_rdata_o,  // read data, next cycle
	input  wire logic [3:0]  pin_in_i,     // pin levels, async
	input  wire logic [7:0]  int_src_i,    // internal sources 9-16
	output logic      [3:0]  pin_out_o,    // pin drive level
	output logic      [3:0]  pin_oe_o,     // pin drive enable
	output logic      [3:0]  rail_en_o,    // 3.3V rail switch
	output logic      [3:0]  soft_out_o    // soft output bits
);

	// ---------------------------------------------------------------
	// configuration state
	// ---------------------------------------------------------------
	logic [1:0]                 line_index_select;   // selected line
	logic [1:0]                 soft_out_bit_select; // selected soft bit
	logic [3:0]                 pin_direction;       // 1 = output
	logic [3:0]                 rail_output_enable;  // rail request
	logic [3:0]                 polarity_invert;     // sense inversion
	logic [3:0]                 filter_kind_select;  // 1 = debounce
	logic [3:0]                 soft_out_packed_word; // soft bits
	logic [`CDIO_FW_W-1:0]      filter_width_us [8]; // {line,kind}
	cdio_pkg::cdio_src_type     pin_drive_select [4]; // per line
	logic [3:0]                 all_pins_level_word; // level snapshot
	logic [3:0]                 pin_level;           // level per line
	logic [3:0]                 drive_val;           // source per line

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	logic                       wr_en;     // qualified write
	logic                       rd_en;     // qualified read
	logic [2:0]                 fw_idx;    // width entry index
	cdio_pkg::cdio_fmt_type     circuit;   // format of selected line
	// a literal cannot be bit-selected, so the rail mask gets a name
	localparam logic [3:0]      rail_lines = `CDIO_RAIL_MASK; // lines with rail

	assign wr_en  = reg_wr_i && clk_en_i;
	assign rd_en  = reg_rd_i && clk_en_i;
	// width entry follows the line and its filter kind
	assign fw_idx = {line_index_select,
		filter_kind_select[line_index_select]}; // RQ9

	// fixed circuit type per line, never written
	always_comb begin
		unique case (line_index_select) // RQ11
			2'h0:    circuit = cdio_pkg::CDIO_FMT_OPTO;
			2'h1:    circuit = cdio_pkg::CDIO_FMT_OPTO;
			2'h2:    circuit = cdio_pkg::CDIO_FMT_OPENDRN;
			default: circuit = cdio_pkg::CDIO_FMT_TRISTATE;
		endcase
	end

	// ---------------------------------------------------------------
	// selectors
	// ---------------------------------------------------------------
	// line and soft bit selectors
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			line_index_select   <= 2'h0;
			soft_out_bit_select <= 2'h0;
		end else if (wr_en) begin
			// only the addressed selector moves
			if (reg_addr_i == `CDIO_OFS_LINE_SEL) begin
				line_index_select <= reg_wdata_i[1:0]; // RQ1
			end
			if (reg_addr_i == `CDIO_OFS_SOFT_SEL) begin
				soft_out_bit_select <= reg_wdata_i[1:0]; // RQ12
			end
		end
	end

	// ---------------------------------------------------------------
	// per-line control bits
	// ---------------------------------------------------------------
	// direction, rail, inversion and filter kind of selected line
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pin_direction      <= `CDIO_RST_LINES; // RQ19
			rail_output_enable <= `CDIO_RST_LINES; // RQ19
			polarity_invert    <= `CDIO_RST_LINES; // RQ19
			filter_kind_select <= `CDIO_RST_LINES;
		end else if (wr_en) begin
			unique case (reg_addr_i)
				`CDIO_OFS_DIR: begin
					pin_direction[line_index_select] <= reg_wdata_i[0]; // RQ2
				end
				`CDIO_OFS_RAIL: begin
					rail_output_enable[line_index_select] <= reg_wdata_i[0]; // RQ3
				end
				`CDIO_OFS_INV: begin
					polarity_invert[line_index_select] <= reg_wdata_i[0]; // RQ5
				end
				`CDIO_OFS_FILT_KIND: begin
					filter_kind_select[line_index_select] <= reg_wdata_i[0]; // RQ8
				end
				default: begin
					// other offsets leave these bits alone
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// filter widths and drive selects
	// ---------------------------------------------------------------
	// one width per line and kind, one source per line
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 8; i++) begin
				filter_width_us[i] <= `CDIO_RST_FW;
			end
			for (int i = 0; i < 4; i++) begin
				pin_drive_select[i] <= `CDIO_RST_SRC;
			end
		end else if (wr_en) begin
			if (reg_addr_i == `CDIO_OFS_FILT_WIDTH) begin
				filter_width_us[fw_idx] <= reg_wdata_i[`CDIO_FW_W-1:0]; // RQ9
			end
			if (reg_addr_i == `CDIO_OFS_DRIVE_SEL) begin
				pin_drive_select[line_index_select] <=
					reg_wdata_i[`CDIO_SRC_W-1:0]; // RQ10
			end
		end
	end

	// ---------------------------------------------------------------
	// soft output bits
	// ---------------------------------------------------------------
	// single bit via selector, or all bits packed
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			soft_out_packed_word <= `CDIO_RST_LINES; // RQ19
		end else if (wr_en) begin
			if (reg_addr_i == `CDIO_OFS_SOFT_VAL) begin
				soft_out_packed_word[soft_out_bit_select] <= reg_wdata_i[0]; // RQ13
			end
			if (reg_addr_i == `CDIO_OFS_SOFT_ALL) begin
				soft_out_packed_word <= reg_wdata_i[3:0]; // RQ14
			end
		end
	end

	assign soft_out_o = soft_out_packed_word;

	// ---------------------------------------------------------------
	// per-line datapath
	// ---------------------------------------------------------------
	genvar n;
	generate
		for (n = 0; n < `CDIO_LINES; n++) begin : g_line
			logic                  sync_a;   // first sync stage
			logic                  sync_b;   // second sync stage
			logic                  glitch_q; // deglitch output
			logic                  bounce_q; // debounce output
			logic [`CDIO_CNT_W-1:0] glitch_cnt; // held-level count
			logic [`CDIO_CNT_W-1:0] lock_cnt;   // lockout count
			logic [`CDIO_CNT_W-1:0] glitch_cyc; // width in cycles
			logic [`CDIO_CNT_W-1:0] bounce_cyc; // width in cycles
			logic                  next_drive; // chosen source
			logic [`CDIO_SRC_W-1:0] sel;       // this line's source

			// microseconds to whole cycles, never short
			assign glitch_cyc = `CDIO_CNT_W'(filter_width_us[2*n] *
				`CDIO_CYC_PER_US); // RQ18
			assign bounce_cyc = `CDIO_CNT_W'(filter_width_us[2*n+1] *
				`CDIO_CYC_PER_US); // RQ18
			assign sel = pin_drive_select[n];

			// two-flop synchroniser for the pin
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					sync_a <= 1'b0;
					sync_b <= 1'b0;
				end else if (clk_en_i) begin
					sync_a <= pin_in_i[n]; // RQ18
					sync_b <= sync_a;
				end
			end

			// deglitch: change only after full width held
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					glitch_q   <= 1'b0;
					glitch_cnt <= '0;
				end else if (clk_en_i) begin
					if (sync_b == glitch_q) begin
						// level agrees, restart the hold count
						glitch_cnt <= '0;
					end else if (glitch_cnt + 1'b1 >= glitch_cyc) begin
						glitch_q   <= sync_b; // RQ15
						glitch_cnt <= '0;
					end else begin
						glitch_cnt <= glitch_cnt + 1'b1;
					end
				end
			end

			// debounce: first edge passes, then locked out
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					bounce_q <= 1'b0;
					lock_cnt <= '0;
				end else if (clk_en_i) begin
					if (lock_cnt != '0) begin
						// lockout running, changes ignored
						lock_cnt <= lock_cnt - 1'b1; // RQ16
					end else if (glitch_q != bounce_q) begin
						bounce_q <= glitch_q; // RQ16 RQ17
						lock_cnt <= bounce_cyc;
					end
				end
			end

			// choose the internal signal for this line
			always_comb begin
				if (sel == 5'h00) begin
					next_drive = 1'b0;
				end else if (sel < 5'h05) begin
					next_drive = pin_level[2'(sel - 5'h01)];
				end else if (sel < 5'h09) begin
					next_drive = soft_out_packed_word[2'(sel - 5'h05)];
				end else if (sel < 5'h11) begin
					next_drive = int_src_i[3'(sel - 5'h09)];
				end else begin
					// unused code drives low
					next_drive = 1'b0;
				end
			end

			// registered drive, level and pin outputs
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					drive_val[n] <= 1'b0;
					pin_level[n] <= 1'b0;
					pin_out_o[n] <= 1'b0;
					pin_oe_o[n]  <= 1'b0;
					rail_en_o[n] <= 1'b0;
				end else if (clk_en_i) begin
					drive_val[n] <= next_drive;
					// output lines report their drive value
					pin_level[n] <= pin_direction[n] ?
						drive_val[n] : (bounce_q ^ polarity_invert[n]); // RQ6 RQ5
					// source reaches the pin only in output mode
					pin_out_o[n] <= pin_direction[n] &
						(drive_val[n] ^ polarity_invert[n]); // RQ10 RQ5
					pin_oe_o[n]  <= pin_direction[n]; // RQ2
					// rail only on the lines that carry it
					rail_en_o[n] <= rail_output_enable[n] &
						rail_lines[n]; // RQ4
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// packed level snapshot
	// ---------------------------------------------------------------
	// all levels taken on one edge
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			all_pins_level_word <= 4'h0;
		end else if (clk_en_i) begin
			all_pins_level_word <= pin_level; // RQ7
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	// data stands one cycle after the strobe, else zero
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (clk_en_i) begin
			reg_rdata_o <= 32'h0000_0000;
			if (rd_en) begin
				unique case (reg_addr_i)
					`CDIO_OFS_LINE_SEL:
						reg_rdata_o <= {30'h0, line_index_select};
					`CDIO_OFS_DIR:
						reg_rdata_o <= {31'h0, pin_direction[line_index_select]};
					`CDIO_OFS_RAIL:
						reg_rdata_o <= {31'h0, rail_output_enable[line_index_select]};
					`CDIO_OFS_INV:
						reg_rdata_o <= {31'h0, polarity_invert[line_index_select]};
					`CDIO_OFS_LEVEL:
						reg_rdata_o <= {31'h0, pin_level[line_index_select]}; // RQ6
					`CDIO_OFS_LEVEL_ALL:
						reg_rdata_o <= {28'h0, all_pins_level_word}; // RQ7
					`CDIO_OFS_FILT_KIND:
						reg_rdata_o <= {31'h0, filter_kind_select[line_index_select]};
					`CDIO_OFS_FILT_WIDTH:
						reg_rdata_o <= {20'h0, filter_width_us[fw_idx]};
					`CDIO_OFS_DRIVE_SEL:
						reg_rdata_o <= {27'h0, pin_drive_select[line_index_select]};
					`CDIO_OFS_CIRCUIT:
						reg_rdata_o <= {30'h0, circuit}; // RQ11
					`CDIO_OFS_SOFT_SEL:
						reg_rdata_o <= {30'h0, soft_out_bit_select};
					`CDIO_OFS_SOFT_VAL:
						reg_rdata_o <= {31'h0,
							soft_out_packed_word[soft_out_bit_select]}; // RQ13
					`CDIO_OFS_SOFT_ALL:
						reg_rdata_o <= {28'h0, soft_out_packed_word}; // RQ14
					default:
						// unmapped address reads zero
						reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // cdio_lines

// File: core/cdio_defines.svh
// register offsets, reset values and timing counts of the digital i/o lines
`ifndef CDIO_DEFINES_SVH
`define CDIO_DEFINES_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CDIO_OFS_LINE_SEL   6'h00
`define CDIO_OFS_DIR        6'h04
`define CDIO_OFS_RAIL       6'h08
`define CDIO_OFS_INV        6'h0c
`define CDIO_OFS_LEVEL      6'h10
`define CDIO_OFS_LEVEL_ALL  6'h14
`define CDIO_OFS_FILT_KIND  6'h18
`define CDIO_OFS_FILT_WIDTH 6'h1c
`define CDIO_OFS_DRIVE_SEL  6'h20
`define CDIO_OFS_CIRCUIT    6'h24
`define CDIO_OFS_SOFT_SEL   6'h28
`define CDIO_OFS_SOFT_VAL   6'h2c
`define CDIO_OFS_SOFT_ALL   6'h30
// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define CDIO_LINES       4
`define CDIO_FW_W        12
`define CDIO_CNT_W       20
`define CDIO_SRC_W       5
`define CDIO_RST_FW      12'h000
`define CDIO_RST_SRC     5'h00
`define CDIO_RST_LINES   4'h0
`define CDIO_RAIL_MASK   4'h4
// ---------------------------------------------------------------
// timing: filter width unit and clock period
// ---------------------------------------------------------------
`define CDIO_US_NS       1000
`define CDIO_CLK_NS      8
`define CDIO_CYC_PER_US  ((`CDIO_US_NS + `CDIO_CLK_NS - 1) / `CDIO_CLK_NS)
`endif

// File: core/cdio_pkg.sv
// types shared by the digital i/o line logic
package cdio_pkg;
	// direction of one line
	typedef enum logic {
		CDIO_DIR_IN  = 1'b0,
		CDIO_DIR_OUT = 1'b1
	} cdio_dir_type;
	// which input filter the width access reaches
	typedef enum logic {
		CDIO_FILT_DEGLITCH = 1'b0,
		CDIO_FILT_DEBOUNCE = 1'b1
	} cdio_filt_type;
	// electrical circuit type of a line
	typedef enum logic [1:0] {
		CDIO_FMT_TRISTATE = 2'h0,
		CDIO_FMT_OPTO     = 2'h1,
		CDIO_FMT_OPENDRN  = 2'h2
	} cdio_fmt_type;
	// drive source codes: 0 off, 1-4 lines, 5-8 soft outs, 9-16 internal
	typedef logic [4:0] cdio_src_type;
endpackage

// File: verification/cdio_lines_asserts.sv
// port checker for the digital i/o lines
`timescale 1ns/1ps
`include "cdio_defines.svh"

module cdio_lines_asserts (
	input wire logic        sys_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        clk_en_i,
	input wire logic [5:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic [3:0]  pin_out_o,
	input wire logic [3:0]  pin_oe_o,
	input wire logic [3:0]  rail_en_o,
	input wire logic [3:0]  soft_out_o
);
	// ----
	// helpers
	// ----
	logic wr;  // write taken
	logic rd;  // read taken
	assign wr = reg_wr_i & clk_en_i;
	assign rd = reg_rd_i & clk_en_i;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// a taken read of one offset
	sequence s_rd_at(a);
		rd && reg_addr_i == a;
	endsequence
	// a packed soft word write
	sequence s_soft_wr;
		wr && reg_addr_i == `CDIO_OFS_SOFT_ALL;
	endsequence
	// ----
	// assertions
	// ----
	a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=>
		{pin_out_o, pin_oe_o, rail_en_o, soft_out_o} == 16'h0 && reg_rdata_o == 32'h0)
		else $error("outputs not cleared by reset");
	a_rail_subset: assert property ((rail_en_o & ~`CDIO_RAIL_MASK) == 4'h0)
		else $error("rail on a line without rail");
	a_rdata_idle: assert property (clk_en_i && !reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data without read");
	a_rdata_freeze: assert property (!clk_en_i |=> $stable(reg_rdata_o))
		else $error("read data moved while frozen");
	a_soft_packed: assert property (s_soft_wr |=> soft_out_o == $past(reg_wdata_i[3:0]))
		else $error("packed soft write lost");
	a_soft_readback: assert property (s_rd_at(`CDIO_OFS_SOFT_ALL) |=>
		reg_rdata_o == {28'h0, $past(soft_out_o)})
		else $error("packed soft read wrong");
	a_circuit_code: assert property (s_rd_at(`CDIO_OFS_CIRCUIT) |=> reg_rdata_o < 32'h3)
		else $error("circuit type out of range");
	a_level_narrow: assert property (s_rd_at(`CDIO_OFS_LEVEL_ALL) |=>
		reg_rdata_o[31:4] == 28'h0)
		else $error("level word too wide");
	a_unmapped_zero: assert property (rd && reg_addr_i > `CDIO_OFS_SOFT_ALL |=>
		reg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_dir_to_oe: assert property ($changed(pin_oe_o) && !$past(sys_rst_i) |->
		$past(wr && reg_addr_i == `CDIO_OFS_DIR, 2))
		else $error("drive enable moved without direction write");
	a_soft_cause: assert property ($changed(soft_out_o) && !$past(sys_rst_i) |->
		$past(wr && (reg_addr_i == `CDIO_OFS_SOFT_VAL || reg_addr_i == `CDIO_OFS_SOFT_ALL)))
		else $error("soft bits moved without write");
endmodule // cdio_lines_asserts

bind cdio_lines cdio_lines_asserts u_chk (.sys_clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pin_out_o, .pin_oe_o, .rail_en_o,
	.soft_out_o);

// File: verification/cdio_pins_model.sv
// external circuits wired to the four connector pins
`timescale 1ns/1ps

module cdio_pins_model (
	input  wire logic [3:0] pin_out_i,  // device drive level
	input  wire logic [3:0] pin_oe_i,   // device drive enable
	input  wire logic [3:0] ext_lvl_i,  // level our circuits apply
	output logic      [3:0] pin_o       // level on the wire
);
	// a driven pin loops the device level back, else ours
	always_comb
		for (int n = 0; n < 4; n++)
			pin_o[n] = (pin_oe_i[n] === 1'b1) ? pin_out_i[n] : ext_lvl_i[n];
endmodule // cdio_pins_model

// File: verification/cdio_lines_tb.sv
// self-checking bench for the digital i/o lines
`timescale 1ns/1ps
`include "cdio_defines.svh"

module cdio_lines_tb;
	logic        sys_clk_i = 0, sys_rst_i = 1, clk_en_i = 1, reg_wr_i = 0, reg_rd_i = 0;
	logic [5:0]  reg_addr_i = 0;
	logic [31:0] reg_wdata_i = 0, reg_rdata_o;
	logic [3:0]  pin_in_i, pin_out_o, pin_oe_o, rail_en_o, soft_out_o, ext_lvl = 0;
	logic [7:0]  int_src_i = 0;
	logic [3:0]  m_inv = 0;  // model: inversion per line
	logic [1:0]  fmt [4] = '{2'h1, 2'h1, 2'h2, 2'h0};  // model: circuit types
	logic        e;          // model: expected drive
	int          m_soft, b, mismatches = 0, compares = 0, cyc = 0;

	cdio_lines uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pin_in_i(pin_in_i),
		.int_src_i(int_src_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.rail_en_o(rail_en_o), .soft_out_o(soft_out_o));
	cdio_pins_model u_pins (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_lvl_i(ext_lvl),
		.pin_o(pin_in_i));

	always #4 sys_clk_i = ~sys_clk_i;
	// ----
	// bus, compare and closing tasks
	// ----
	task automatic wr(input logic [5:0] a, input int d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= 32'(d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic cmp_reg(input logic [5:0] a, input int x, input logic [31:0] g);
		compares++;
		if (g !== 32'(x)) begin
			mismatches++;
			$display("MISMATCH reg %h exp %h got %h", a, 32'(x), g);
		end
	endtask
	task automatic rd_chk(input logic [5:0] a, input int x);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		cmp_reg(a, x, reg_rdata_o);
	endtask
	task automatic cmp_pin(input string nm, input logic [3:0] x, input logic [3:0] g);
		compares++;
		if (g !== x) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	// ----
	// scenarios
	// ----
	initial begin
		void'($urandom(32'h8439));
		repeat (16) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		// reset state, circuit types, rail request on every line
		for (int n = 0; n < 4; n++) begin
			wr(`CDIO_OFS_LINE_SEL, n);
			rd_chk(`CDIO_OFS_DIR, 0);
			rd_chk(`CDIO_OFS_INV, 0);
			wr(`CDIO_OFS_CIRCUIT, 3);
			rd_chk(`CDIO_OFS_CIRCUIT, fmt[n]);
			wr(`CDIO_OFS_RAIL, 1);
		end
		repeat (4) @(posedge sys_clk_i);
		#1 cmp_pin("rail", 4'h4, rail_en_o);
		rd_chk(6'h38, 0);
		// soft outputs, packed then bit by bit
		m_soft = $urandom % 16;
		wr(`CDIO_OFS_SOFT_ALL, m_soft);
		#1 cmp_pin("soft", m_soft[3:0], soft_out_o);
		for (int k = 0; k < 4; k++) begin
			b = $urandom % 2;
			m_soft[k] = b[0];
			wr(`CDIO_OFS_SOFT_SEL, k);
			wr(`CDIO_OFS_SOFT_VAL, b);
			rd_chk(`CDIO_OFS_SOFT_VAL, b);
			rd_chk(`CDIO_OFS_SOFT_ALL, m_soft);
		end
		// frozen clock enable drops a write
		@(posedge sys_clk_i) clk_en_i <= 1'b0;
		wr(`CDIO_OFS_SOFT_ALL, ~m_soft);
		@(posedge sys_clk_i) clk_en_i <= 1'b1;
		#1 cmp_pin("frozen", m_soft[3:0], soft_out_o);
		// input levels, line 1 inverted
		wr(`CDIO_OFS_LINE_SEL, 1);
		wr(`CDIO_OFS_INV, 1);
		m_inv = 4'h2;
		repeat (5) begin
			ext_lvl <= 4'($urandom);
			repeat (10) @(posedge sys_clk_i);
			rd_chk(`CDIO_OFS_LEVEL_ALL, ext_lvl ^ m_inv);
			for (int n = 0; n < 4; n++) begin
				wr(`CDIO_OFS_LINE_SEL, n);
				rd_chk(`CDIO_OFS_LEVEL, ext_lvl[n] ^ m_inv[n]);
			end
		end
		// line 3 drives codes 0 to 17: off, loop-back, soft, internal, unused
		wr(`CDIO_OFS_DIR, 1);
		wr(`CDIO_OFS_INV, 1);
		m_inv[3] = 1'b1;
		for (int c = 0; c < 18; c++) begin
			int_src_i <= 8'($urandom);
			wr(`CDIO_OFS_DRIVE_SEL, c);
			repeat (3) @(posedge sys_clk_i);
			#1;
			if (c == 0 || c > 16)
				e = 1'b0;
			else if (c < 4)
				e = ext_lvl[c-1] ^ m_inv[c-1];
			else if (c > 8)
				e = int_src_i[c-9];
			else if (c > 4)
				e = m_soft[c-5];
			// code 4 loops line 3 onto itself, so it keeps its last value
			cmp_pin("drive", {~e, 3'h0}, pin_out_o & 4'h8);
			cmp_pin("enable", 4'h8, pin_oe_o);
			rd_chk(`CDIO_OFS_LEVEL, e);
		end
		wr(`CDIO_OFS_DIR, 0);
		repeat (3) @(posedge sys_clk_i);
		#1 cmp_pin("released", 4'h0, pin_oe_o | pin_out_o);
		// deglitch on line 0: short pulse rejected, long level late
		ext_lvl <= 4'h0;
		wr(`CDIO_OFS_LINE_SEL, 0);
		wr(`CDIO_OFS_FILT_KIND, 0);
		wr(`CDIO_OFS_FILT_WIDTH, 1);
		ext_lvl[0] <= 1'b1;
		repeat (60) @(posedge sys_clk_i);
		ext_lvl[0] <= 1'b0;
		repeat (100) @(posedge sys_clk_i);
		rd_chk(`CDIO_OFS_LEVEL, 0);
		ext_lvl[0] <= 1'b1;
		repeat (100) @(posedge sys_clk_i);
		rd_chk(`CDIO_OFS_LEVEL, 0);
		repeat (50) @(posedge sys_clk_i);
		rd_chk(`CDIO_OFS_LEVEL, 1);
		// debounce on line 1: first edge passes, then lockout
		wr(`CDIO_OFS_LINE_SEL, 1);
		wr(`CDIO_OFS_FILT_KIND, 1);
		wr(`CDIO_OFS_FILT_WIDTH, 1);
		ext_lvl[1] <= 1'b1;
		repeat (10) @(posedge sys_clk_i);
		rd_chk(`CDIO_OFS_LEVEL, 0);
		ext_lvl[1] <= 1'b0;
		repeat (40) @(posedge sys_clk_i);
		rd_chk(`CDIO_OFS_LEVEL, 0);
		repeat (150) @(posedge sys_clk_i);
		rd_chk(`CDIO_OFS_LEVEL, 1);
		rd_chk(`CDIO_OFS_FILT_WIDTH, 1);
		wr(`CDIO_OFS_FILT_KIND, 0);
		rd_chk(`CDIO_OFS_FILT_WIDTH, 0);
		stop_test();
	end
endmodule // cdio_lines_tb
